// >>> exb_pkg.sv
// Types, constants and small helpers shared by the extended-bank ALU datapath.
// Assumes one core clock and a decoder that presents at most one operation per cycle.
package exb_pkg;

    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam int MSB = 7;
    localparam int LSB = 0;
    localparam int BIT_SEL_W = 3;
    localparam logic [BYTE_W-1:0] ALL_ONES = 8'hFF;
    localparam logic [BYTE_W-1:0] ALL_ZEROS = 8'h00;
    localparam logic [BYTE_W-1:0] ONE = 8'h01;

    typedef enum logic [4:0] {
        OR_INTO_WORK_REG,
        OR_INTO_MEMORY,
        ROTATE_LEFT_IN_PLACE,
        ROTATE_LEFT_TO_WORK_REG,
        ROTATE_LEFT_THROUGH_CARRY,
        ROTATE_LEFT_CARRY_TO_WORK_REG,
        ROTATE_RIGHT_IN_PLACE,
        ROTATE_RIGHT_TO_WORK_REG,
        ROTATE_RIGHT_THROUGH_CARRY,
        ROTATE_RIGHT_CARRY_TO_WORK_REG,
        SUBTRACT_BORROW_TO_WORK_REG,
        SUBTRACT_BORROW_TO_MEMORY,
        SUBTRACT_TO_WORK_REG,
        SUBTRACT_TO_MEMORY,
        DECREMENT_SKIP_ZERO,
        DECREMENT_SKIP_ZERO_TO_WORK_REG,
        INCREMENT_SKIP_ZERO,
        INCREMENT_SKIP_ZERO_TO_WORK_REG,
        FILL_ONES,
        FILL_ONE_BIT,
        SKIP_IF_NONZERO,
        SKIP_IF_BIT_NONZERO,
        NIBBLE_EXCHANGE,
        NIBBLE_EXCHANGE_TO_WORK_REG
    } exb_op_t;

    typedef enum logic {
        ST_READY,
        ST_DUMMY
    } exb_state_t;

    typedef struct packed {
        logic signed_range_exceeded_flag;
        logic zero_flag;
        logic nibble_carry_flag;
        logic carry_flag;
        logic signed_compare_flag;
        logic chained_zero_flag;
    } exb_flags_t;

    localparam exb_flags_t FLAGS_NONE = 6'h00;
    localparam exb_flags_t FLAGS_ZERO = 6'h10;
    localparam exb_flags_t FLAGS_CARRY = 6'h04;
    localparam exb_flags_t FLAGS_SUB = 6'h3F;

    typedef struct packed {
        exb_op_t op;
        logic [BIT_SEL_W-1:0] bit_sel;
        logic [BYTE_W-1:0] mem_byte;
        logic [BYTE_W-1:0] work_register;
        exb_flags_t flags;
    } exb_req_t;

    typedef struct packed {
        logic work_we;
        logic [BYTE_W-1:0] work_data;
        logic mem_we;
        logic [BYTE_W-1:0] mem_data;
        exb_flags_t flags;
        exb_flags_t flag_we;
        logic skip;
    } exb_rsp_t;

    function automatic logic is_zero(input logic [BYTE_W-1:0] v);
        return v == ALL_ZEROS;
    endfunction

    function automatic logic [BYTE_W-1:0] rot_left(input logic [BYTE_W-1:0] v, input logic fill);
        return {v[MSB-1:LSB], fill};
    endfunction

    function automatic logic [BYTE_W-1:0] rot_right(input logic [BYTE_W-1:0] v, input logic fill);
        return {fill, v[MSB:LSB+1]};
    endfunction

    function automatic logic [BYTE_W-1:0] swap_nibbles(input logic [BYTE_W-1:0] v);
        return {v[NIB_W-1:LSB], v[MSB:NIB_W]};
    endfunction

endpackage

// >>> exb_sub_unit.sv
// Eight-bit subtractor with the full arithmetic flag set.
// Assumes the caller passes borrow_in already inverted from carry, and chain_in high
// when the chained zero flag should simply follow the zero flag.
`timescale 1ns/1ps
module exb_sub_unit (
    input wire logic [exb_pkg::BYTE_W-1:0] minuend,
    input wire logic [exb_pkg::BYTE_W-1:0] subtrahend,
    input wire logic borrow_in,
    input wire logic chain_in,
    output logic [exb_pkg::BYTE_W-1:0] diff,
    output exb_pkg::exb_flags_t flags
);
    logic [exb_pkg::BYTE_W:0] wide;
    logic [exb_pkg::NIB_W:0] low;

    assign wide = {1'h0, minuend} - {1'h0, subtrahend} - {8'h00, borrow_in};
    assign low = {1'h0, minuend[exb_pkg::NIB_W-1:0]}
        - {1'h0, subtrahend[exb_pkg::NIB_W-1:0]} - {4'h0, borrow_in};
    assign diff = wide[exb_pkg::BYTE_W-1:0];

    // Carry reads as "no borrow": a negative result clears it.
    always_comb begin
        flags.carry_flag = !wide[exb_pkg::BYTE_W];
        flags.nibble_carry_flag = !low[exb_pkg::NIB_W];
        flags.zero_flag = exb_pkg::is_zero(diff);
        flags.chained_zero_flag = exb_pkg::is_zero(diff) && chain_in;
        flags.signed_range_exceeded_flag = (minuend[exb_pkg::MSB] ^ subtrahend[exb_pkg::MSB])
            && (minuend[exb_pkg::MSB] ^ diff[exb_pkg::MSB]);
        flags.signed_compare_flag = flags.signed_range_exceeded_flag ^ diff[exb_pkg::MSB];
    end

endmodule // exb_sub_unit

// >>> exb_alu.sv
// Execution datapath for the extended memory instructions: OR, rotates, subtracts,
// set, increment/decrement-and-skip, nonzero skips and nibble swap.
// Assumes the decoder supplies the operand byte and flags with each request on the
// core clock and writes back whatever the registered answer asks for.
// How it works
// - OR work register with memory byte, result to either, zero flag only.
// - Rotate left, bit 7 into bit 0, to memory or work register.
// - Rotate left through carry; old carry into bit 0, bit 7 to carry.
// - Rotate right, bit 0 into bit 7, to memory or work register.
// - Rotate right through carry; old carry into bit 7, bit 0 to carry.
// - Work minus memory minus inverted carry; six flags; carry set unless negative.
// - Work minus memory; same six flags; carry set unless negative.
// - Memory minus one back to memory; skip with dummy cycle on zero.
// - Memory minus one into work register only; skip when zero.
// - Fill the memory byte with all ones; flags untouched.
// - Set the selected memory bit; other bits and flags untouched.
// - Memory plus one back to memory; skip with dummy cycle on zero.
// - Memory plus one into work register only; skip when zero.
// - Skip next instruction when the selected memory bit is one.
// - Skip next instruction when the memory byte is nonzero.
// - Swap nibbles, to memory or work register; flags untouched.
`timescale 1ns/1ps
module exb_alu (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire exb_pkg::exb_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output exb_pkg::exb_rsp_t rsp,
    output logic dummy_cycle
);
    typedef struct packed {
        exb_pkg::exb_state_t st;
        logic ready;
        logic rsp_valid;
        exb_pkg::exb_rsp_t rsp;
        logic dummy;
    } exb_alu_state_t;

    exb_alu_state_t q;
    exb_alu_state_t next_q;
    logic take;
    logic sub_borrow;
    logic sub_chain;
    logic [exb_pkg::BYTE_W-1:0] sub_diff;
    exb_pkg::exb_flags_t sub_flags;

    assign take = req_valid && q.ready;

    assign sub_borrow = (req.op == exb_pkg::SUBTRACT_BORROW_TO_WORK_REG
        || req.op == exb_pkg::SUBTRACT_BORROW_TO_MEMORY) && !req.flags.carry_flag;
    assign sub_chain = (req.op == exb_pkg::SUBTRACT_TO_WORK_REG
        || req.op == exb_pkg::SUBTRACT_TO_MEMORY) || req.flags.chained_zero_flag;

    exb_sub_unit u_sub (
        .minuend(req.work_register),
        .subtrahend(req.mem_byte),
        .borrow_in(sub_borrow),
        .chain_in(sub_chain),
        .diff(sub_diff),
        .flags(sub_flags)
    );

    always_comb begin
        exb_pkg::exb_rsp_t c;
        logic [exb_pkg::BYTE_W-1:0] res;
        logic to_work;
        logic writes;
        c = '0;
        res = req.mem_byte;
        to_work = 1'b0;
        writes = 1'b1;
        next_q = q;
        c.flags = req.flags;
        c.flag_we = exb_pkg::FLAGS_NONE;
        case (req.op)
            exb_pkg::OR_INTO_WORK_REG, exb_pkg::OR_INTO_MEMORY: begin
                res = req.work_register | req.mem_byte;
                to_work = req.op == exb_pkg::OR_INTO_WORK_REG;
                c.flag_we = exb_pkg::FLAGS_ZERO;
            end
            exb_pkg::ROTATE_LEFT_IN_PLACE, exb_pkg::ROTATE_LEFT_TO_WORK_REG: begin
                res = exb_pkg::rot_left(req.mem_byte, req.mem_byte[exb_pkg::MSB]);
                to_work = req.op == exb_pkg::ROTATE_LEFT_TO_WORK_REG;
            end
            exb_pkg::ROTATE_LEFT_THROUGH_CARRY, exb_pkg::ROTATE_LEFT_CARRY_TO_WORK_REG: begin
                res = exb_pkg::rot_left(req.mem_byte, req.flags.carry_flag);
                to_work = req.op == exb_pkg::ROTATE_LEFT_CARRY_TO_WORK_REG;
                c.flags.carry_flag = req.mem_byte[exb_pkg::MSB];
                c.flag_we = exb_pkg::FLAGS_CARRY;
            end
            exb_pkg::ROTATE_RIGHT_IN_PLACE, exb_pkg::ROTATE_RIGHT_TO_WORK_REG: begin
                res = exb_pkg::rot_right(req.mem_byte, req.mem_byte[exb_pkg::LSB]);
                to_work = req.op == exb_pkg::ROTATE_RIGHT_TO_WORK_REG;
            end
            exb_pkg::ROTATE_RIGHT_THROUGH_CARRY, exb_pkg::ROTATE_RIGHT_CARRY_TO_WORK_REG: begin
                res = exb_pkg::rot_right(req.mem_byte, req.flags.carry_flag);
                to_work = req.op == exb_pkg::ROTATE_RIGHT_CARRY_TO_WORK_REG;
                c.flags.carry_flag = req.mem_byte[exb_pkg::LSB];
                c.flag_we = exb_pkg::FLAGS_CARRY;
            end
            exb_pkg::SUBTRACT_BORROW_TO_WORK_REG, exb_pkg::SUBTRACT_BORROW_TO_MEMORY,
            exb_pkg::SUBTRACT_TO_WORK_REG, exb_pkg::SUBTRACT_TO_MEMORY: begin
                res = sub_diff;
                to_work = req.op == exb_pkg::SUBTRACT_BORROW_TO_WORK_REG
                    || req.op == exb_pkg::SUBTRACT_TO_WORK_REG;
                c.flags = sub_flags;
                c.flag_we = exb_pkg::FLAGS_SUB;
            end
            exb_pkg::DECREMENT_SKIP_ZERO, exb_pkg::DECREMENT_SKIP_ZERO_TO_WORK_REG: begin
                res = req.mem_byte - exb_pkg::ONE;
                to_work = req.op == exb_pkg::DECREMENT_SKIP_ZERO_TO_WORK_REG;
                c.skip = exb_pkg::is_zero(res);
            end
            exb_pkg::INCREMENT_SKIP_ZERO, exb_pkg::INCREMENT_SKIP_ZERO_TO_WORK_REG: begin
                res = req.mem_byte + exb_pkg::ONE;
                to_work = req.op == exb_pkg::INCREMENT_SKIP_ZERO_TO_WORK_REG;
                c.skip = exb_pkg::is_zero(res);
            end
            exb_pkg::FILL_ONES: begin
                res = exb_pkg::ALL_ONES;
            end
            exb_pkg::FILL_ONE_BIT: begin
                res = req.mem_byte | (exb_pkg::ONE << req.bit_sel);
            end
            exb_pkg::SKIP_IF_NONZERO: begin
                writes = 1'b0;
                c.skip = !exb_pkg::is_zero(req.mem_byte);
            end
            exb_pkg::SKIP_IF_BIT_NONZERO: begin
                writes = 1'b0;
                c.skip = req.mem_byte[req.bit_sel];
            end
            exb_pkg::NIBBLE_EXCHANGE, exb_pkg::NIBBLE_EXCHANGE_TO_WORK_REG: begin
                res = exb_pkg::swap_nibbles(req.mem_byte);
                to_work = req.op == exb_pkg::NIBBLE_EXCHANGE_TO_WORK_REG;
            end
            default: begin
                writes = 1'b0;
            end
        endcase
        if (c.flag_we.zero_flag) begin
            c.flags.zero_flag = exb_pkg::is_zero(res);
        end
        c.work_we = writes && to_work;
        c.mem_we = writes && !to_work;
        c.work_data = to_work ? res : req.work_register;
        c.mem_data = to_work ? req.mem_byte : res;

        // The answer stays on rsp until the next taken request so the core may
        // sample it late; only rsp_valid marks the fresh cycle.
        next_q.rsp_valid = 1'b0;
        next_q.dummy = 1'b0;
        case (q.st)
            exb_pkg::ST_READY: begin
                if (take) begin
                    next_q.rsp = c;
                    next_q.rsp_valid = 1'b1;
                    if (c.skip) begin
                        next_q.st = exb_pkg::ST_DUMMY;
                        next_q.ready = 1'b0;
                        next_q.dummy = 1'b1;
                    end
                end
            end
            exb_pkg::ST_DUMMY: begin
                next_q.st = exb_pkg::ST_READY;
                next_q.ready = 1'b1;
            end
            default: begin
                next_q.st = exb_pkg::ST_READY;
                next_q.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{st: exb_pkg::ST_READY, ready: 1'b1, rsp_valid: 1'b0, rsp: '0, dummy: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign req_ready = q.ready;
    assign rsp_valid = q.rsp_valid;
    assign rsp = q.rsp;
    assign dummy_cycle = q.dummy;

    chk_or_work_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::OR_INTO_WORK_REG |=> rsp_valid && rsp.work_we
            && !rsp.mem_we && rsp.flag_we == exb_pkg::FLAGS_ZERO
            && rsp.work_data == ($past(req.work_register) | $past(req.mem_byte)))
        else $error("OR into work register gave a wrong answer");

    chk_rotl_in_place: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::ROTATE_LEFT_IN_PLACE |=> rsp.mem_we && !rsp.work_we
            && rsp.mem_data[exb_pkg::LSB] == $past(req.mem_byte[exb_pkg::MSB])
            && rsp.flag_we == exb_pkg::FLAGS_NONE)
        else $error("Left rotate in place is wrong");

    chk_rlc_carry_out: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::ROTATE_LEFT_CARRY_TO_WORK_REG |=> !rsp.mem_we
            && rsp.work_data[exb_pkg::LSB] == $past(req.flags.carry_flag)
            && rsp.flags.carry_flag == $past(req.mem_byte[exb_pkg::MSB])
            && rsp.flag_we == exb_pkg::FLAGS_CARRY)
        else $error("Left rotate through carry is wrong");

    chk_rotr_work_reg: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::ROTATE_RIGHT_TO_WORK_REG |=> rsp.work_we && !rsp.mem_we
            && rsp.work_data[exb_pkg::MSB] == $past(req.mem_byte[exb_pkg::LSB]))
        else $error("Right rotate to work register is wrong");

    chk_rrc_carry_out: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::ROTATE_RIGHT_THROUGH_CARRY |=> rsp.mem_we
            && rsp.mem_data[exb_pkg::MSB] == $past(req.flags.carry_flag)
            && rsp.flags.carry_flag == $past(req.mem_byte[exb_pkg::LSB]))
        else $error("Right rotate through carry is wrong");

    chk_sbc_borrow_value: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::SUBTRACT_BORROW_TO_WORK_REG && !req.flags.carry_flag
            |=> rsp.work_data == $past(req.work_register) - $past(req.mem_byte) - exb_pkg::ONE
            && rsp.flag_we == exb_pkg::FLAGS_SUB)
        else $error("Subtract with borrow ignored the cleared carry");

    chk_sub_carry_sense: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::SUBTRACT_TO_MEMORY |=> rsp.mem_we
            && rsp.flags.carry_flag == ($past(req.work_register) >= $past(req.mem_byte)))
        else $error("Subtract carry does not mean no borrow");

    chk_dec_skip_timing: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::DECREMENT_SKIP_ZERO && req.mem_byte == exb_pkg::ONE
            |=> rsp.mem_we && dummy_cycle && !req_ready ##1 req_ready && !dummy_cycle)
        else $error("Decrement to zero did not take exactly two cycles");

    chk_dec_work_only: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::DECREMENT_SKIP_ZERO_TO_WORK_REG |=> !rsp.mem_we
            && rsp.work_data == $past(req.mem_byte) - exb_pkg::ONE
            && rsp.skip == exb_pkg::is_zero(rsp.work_data))
        else $error("Decrement to work register is wrong");

    chk_fill_all_ones: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::FILL_ONES |=> rsp.mem_we
            && rsp.mem_data == exb_pkg::ALL_ONES && rsp.flag_we == exb_pkg::FLAGS_NONE)
        else $error("Fill with ones is wrong");

    chk_set_one_bit: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::FILL_ONE_BIT |=> rsp.mem_data[$past(req.bit_sel)]
            && (rsp.mem_data & ~(exb_pkg::ONE << $past(req.bit_sel)))
                == ($past(req.mem_byte) & ~(exb_pkg::ONE << $past(req.bit_sel))))
        else $error("Bit set disturbed other bits");

    chk_inc_skip_timing: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::INCREMENT_SKIP_ZERO |=> rsp.mem_we
            && rsp.mem_data == $past(req.mem_byte) + exb_pkg::ONE
            && dummy_cycle == exb_pkg::is_zero(rsp.mem_data))
        else $error("Increment and skip is wrong");

    chk_inc_work_only: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::INCREMENT_SKIP_ZERO_TO_WORK_REG
            && req.mem_byte == exb_pkg::ALL_ONES |=> !rsp.mem_we && rsp.work_we
            && rsp.skip ##1 req_ready)
        else $error("Increment to work register did not skip");

    chk_bit_test_skip: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::SKIP_IF_BIT_NONZERO |=> !rsp.mem_we && !rsp.work_we
            && dummy_cycle == $past(req.mem_byte[req.bit_sel]))
        else $error("Bit test skip is wrong");

    chk_byte_test_skip: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::SKIP_IF_NONZERO && req.mem_byte == exb_pkg::ALL_ZEROS
            |=> !dummy_cycle && req_ready && rsp.flag_we == exb_pkg::FLAGS_NONE)
        else $error("Zero byte must not skip");

    chk_nibble_swap: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        take && req.op == exb_pkg::NIBBLE_EXCHANGE_TO_WORK_REG |=> !rsp.mem_we
            && rsp.work_data == exb_pkg::swap_nibbles($past(req.mem_byte)))
        else $error("Nibble swap is wrong");

    chk_zero_flag_sense: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        rsp_valid && rsp.flag_we.zero_flag |-> rsp.flags.zero_flag
            == exb_pkg::is_zero(rsp.work_we ? rsp.work_data : rsp.mem_data))
        else $error("Zero flag does not match the written result");

endmodule // exb_alu

// >>> extended_bank_alu_ops_bench.sv
// Self-checking bench for the extended-bank ALU datapath.
// Assumes the bench stands in for the decoder and drives one request per cycle.
`timescale 1ns/1ps
module extended_bank_alu_ops_bench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    exb_pkg::exb_req_t req = '0;
    logic req_ready;
    logic rsp_valid;
    exb_pkg::exb_rsp_t rsp;
    logic dummy_cycle;
    int n_mismatch = 0;
    int checks = 0;

    exb_alu dut (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .req_valid(req_valid),
        .req(req),
        .req_ready(req_ready),
        .rsp_valid(rsp_valid),
        .rsp(rsp),
        .dummy_cycle(dummy_cycle)
    );

    always #20 sys_clk = ~sys_clk;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // The request stays valid after the take, so a skipping answer also shows the refusal.
    task automatic op(input exb_pkg::exb_op_t o, input logic [2:0] b, input logic [7:0] m,
                      input logic [7:0] w, input logic [5:0] f, input logic wwe,
                      input logic [7:0] wd, input logic mwe, input logic [7:0] md,
                      input logic [5:0] fwe, input logic [5:0] fx, input logic sk);
        req_valid = 1'b1;
        req = '{op: o, bit_sel: b, mem_byte: m, work_register: w, flags: f};
        @(posedge sys_clk);
        #1;
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
        chk("work_we", {31'h0, wwe}, {31'h0, rsp.work_we});
        chk("mem_we", {31'h0, mwe}, {31'h0, rsp.mem_we});
        if (wwe)
            chk("work_data", {24'h0, wd}, {24'h0, rsp.work_data});
        if (mwe)
            chk("mem_data", {24'h0, md}, {24'h0, rsp.mem_data});
        chk("flag_we", {26'h0, fwe}, {26'h0, rsp.flag_we});
        chk("flags", {26'h0, fx}, {26'h0, rsp.flags});
        chk("skip", {31'h0, sk}, {31'h0, rsp.skip});
        chk("dummy_cycle", {31'h0, sk}, {31'h0, dummy_cycle});
        chk("req_ready", {31'h0, ~sk}, {31'h0, req_ready});
        if (sk) begin
            @(posedge sys_clk);
            #1;
            chk("refused rsp_valid", 32'h0, {31'h0, rsp_valid});
            chk("dummy_cycle after", 32'h0, {31'h0, dummy_cycle});
            chk("req_ready after", 32'h1, {31'h0, req_ready});
        end
    endtask

    task automatic idle();
        req_valid = 1'b0;
        @(posedge sys_clk);
        #1;
        chk("idle rsp_valid", 32'h0, {31'h0, rsp_valid});
    endtask

    task automatic test_reset();
        chk("reset req_ready", 32'h1, {31'h0, req_ready});
        chk("reset rsp_valid", 32'h0, {31'h0, rsp_valid});
        chk("reset dummy", 32'h0, {31'h0, dummy_cycle});
        chk("reset rsp", 32'h0, {1'b0, rsp});
    endtask

    task automatic test_or();
        op(exb_pkg::OR_INTO_WORK_REG, 3'h0, 8'h0F, 8'hA5, 6'h10,
           '1, 8'hAF, '0, 8'h00, 6'h10, 6'h00, '0);
        op(exb_pkg::OR_INTO_MEMORY, 3'h0, 8'h00, 8'h00, 6'h00,
           '0, 8'h00, '1, 8'h00, 6'h10, 6'h10, '0);
        op(exb_pkg::OR_INTO_MEMORY, 3'h0, 8'h30, 8'h03, 6'h3F,
           '0, 8'h00, '1, 8'h33, 6'h10, 6'h2F, '0);
    endtask

    task automatic test_rotate();
        op(exb_pkg::ROTATE_LEFT_IN_PLACE, 3'h0, 8'h81, 8'h00, 6'h2A,
           '0, 8'h00, '1, 8'h03, 6'h00, 6'h2A, '0);
        op(exb_pkg::ROTATE_LEFT_TO_WORK_REG, 3'h0, 8'h81, 8'h00, 6'h2A,
           '1, 8'h03, '0, 8'h00, 6'h00, 6'h2A, '0);
        op(exb_pkg::ROTATE_LEFT_THROUGH_CARRY, 3'h0, 8'h81, 8'h00, 6'h00,
           '0, 8'h00, '1, 8'h02, 6'h04, 6'h04, '0);
        op(exb_pkg::ROTATE_LEFT_CARRY_TO_WORK_REG, 3'h0, 8'h41, 8'h00, 6'h04,
           '1, 8'h83, '0, 8'h00, 6'h04, 6'h00, '0);
        op(exb_pkg::ROTATE_RIGHT_IN_PLACE, 3'h0, 8'h81, 8'h00, 6'h2A,
           '0, 8'h00, '1, 8'hC0, 6'h00, 6'h2A, '0);
        op(exb_pkg::ROTATE_RIGHT_TO_WORK_REG, 3'h0, 8'h81, 8'h00, 6'h2A,
           '1, 8'hC0, '0, 8'h00, 6'h00, 6'h2A, '0);
        op(exb_pkg::ROTATE_RIGHT_THROUGH_CARRY, 3'h0, 8'h81, 8'h00, 6'h00,
           '0, 8'h00, '1, 8'h40, 6'h04, 6'h04, '0);
        op(exb_pkg::ROTATE_RIGHT_CARRY_TO_WORK_REG, 3'h0, 8'h02, 8'h00, 6'h04,
           '1, 8'h81, '0, 8'h00, 6'h04, 6'h00, '0);
    endtask

    task automatic test_subtract();
        op(exb_pkg::SUBTRACT_TO_WORK_REG, 3'h0, 8'h07, 8'h05, 6'h2A,
           '1, 8'hFE, '0, 8'h00, 6'h3F, 6'h02, '0);
        op(exb_pkg::SUBTRACT_TO_MEMORY, 3'h0, 8'h01, 8'h80, 6'h00,
           '0, 8'h00, '1, 8'h7F, 6'h3F, 6'h26, '0);
        op(exb_pkg::SUBTRACT_BORROW_TO_WORK_REG, 3'h0, 8'h05, 8'h05, 6'h05,
           '1, 8'h00, '0, 8'h00, 6'h3F, 6'h1D, '0);
        op(exb_pkg::SUBTRACT_BORROW_TO_WORK_REG, 3'h0, 8'h01, 8'h03, 6'h00,
           '1, 8'h01, '0, 8'h00, 6'h3F, 6'h0C, '0);
        op(exb_pkg::SUBTRACT_BORROW_TO_MEMORY, 3'h0, 8'h05, 8'h05, 6'h01,
           '0, 8'h00, '1, 8'hFF, 6'h3F, 6'h02, '0);
    endtask

    task automatic test_step_skip();
        op(exb_pkg::DECREMENT_SKIP_ZERO, 3'h0, 8'h05, 8'h00, 6'h2A,
           '0, 8'h00, '1, 8'h04, 6'h00, 6'h2A, '0);
        op(exb_pkg::DECREMENT_SKIP_ZERO, 3'h0, 8'h01, 8'h00, 6'h2A,
           '0, 8'h00, '1, 8'h00, 6'h00, 6'h2A, '1);
        op(exb_pkg::DECREMENT_SKIP_ZERO_TO_WORK_REG, 3'h0, 8'h01, 8'h33, 6'h15,
           '1, 8'h00, '0, 8'h00, 6'h00, 6'h15, '1);
        op(exb_pkg::DECREMENT_SKIP_ZERO_TO_WORK_REG, 3'h0, 8'h00, 8'h33, 6'h15,
           '1, 8'hFF, '0, 8'h00, 6'h00, 6'h15, '0);
        op(exb_pkg::INCREMENT_SKIP_ZERO, 3'h0, 8'hFF, 8'h00, 6'h2A,
           '0, 8'h00, '1, 8'h00, 6'h00, 6'h2A, '1);
        op(exb_pkg::INCREMENT_SKIP_ZERO, 3'h0, 8'h7F, 8'h00, 6'h2A,
           '0, 8'h00, '1, 8'h80, 6'h00, 6'h2A, '0);
        op(exb_pkg::INCREMENT_SKIP_ZERO_TO_WORK_REG, 3'h0, 8'hFF, 8'h11, 6'h15,
           '1, 8'h00, '0, 8'h00, 6'h00, 6'h15, '1);
        op(exb_pkg::INCREMENT_SKIP_ZERO_TO_WORK_REG, 3'h0, 8'hFE, 8'h11, 6'h15,
           '1, 8'hFF, '0, 8'h00, 6'h00, 6'h15, '0);
    endtask

    task automatic test_set_test();
        op(exb_pkg::FILL_ONES, 3'h0, 8'h12, 8'h00, 6'h2A,
           '0, 8'h00, '1, 8'hFF, 6'h00, 6'h2A, '0);
        op(exb_pkg::FILL_ONE_BIT, 3'h5, 8'h00, 8'h00, 6'h15,
           '0, 8'h00, '1, 8'h20, 6'h00, 6'h15, '0);
        op(exb_pkg::FILL_ONE_BIT, 3'h7, 8'h7F, 8'h00, 6'h15,
           '0, 8'h00, '1, 8'hFF, 6'h00, 6'h15, '0);
        op(exb_pkg::SKIP_IF_BIT_NONZERO, 3'h3, 8'h08, 8'h00, 6'h2A,
           '0, 8'h00, '0, 8'h00, 6'h00, 6'h2A, '1);
        op(exb_pkg::SKIP_IF_BIT_NONZERO, 3'h2, 8'hFB, 8'h00, 6'h2A,
           '0, 8'h00, '0, 8'h00, 6'h00, 6'h2A, '0);
        op(exb_pkg::SKIP_IF_NONZERO, 3'h0, 8'h00, 8'h00, 6'h2A,
           '0, 8'h00, '0, 8'h00, 6'h00, 6'h2A, '0);
        op(exb_pkg::SKIP_IF_NONZERO, 3'h0, 8'h80, 8'h00, 6'h2A,
           '0, 8'h00, '0, 8'h00, 6'h00, 6'h2A, '1);
        op(exb_pkg::NIBBLE_EXCHANGE, 3'h0, 8'h3C, 8'h00, 6'h2A,
           '0, 8'h00, '1, 8'hC3, 6'h00, 6'h2A, '0);
        op(exb_pkg::NIBBLE_EXCHANGE_TO_WORK_REG, 3'h0, 8'h1E, 8'h00, 6'h2A,
           '1, 8'hE1, '0, 8'h00, 6'h00, 6'h2A, '0);
    endtask

    // A reset in the dummy cycle must drop the held answer, not leave it for the core.
    task automatic test_mid_reset();
        req_valid = 1'b1;
        req = '{op: exb_pkg::INCREMENT_SKIP_ZERO, bit_sel: 3'h0, mem_byte: 8'hFF,
                work_register: 8'h00, flags: 6'h00};
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        rst_b = 1'b0;
        @(posedge sys_clk);
        #1;
        test_reset();
        rst_b = 1'b1;
    endtask

    task automatic end_of_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // The whole sequence needs well under a hundred cycles; this limit leaves ample margin.
    initial begin
        #(40 * 4000);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        test_reset();
        rst_b = 1'b1;
        test_or();
        test_rotate();
        test_subtract();
        idle();
        test_step_skip();
        test_mid_reset();
        test_set_test();
        idle();
        end_of_test();
    end
endmodule // extended_bank_alu_ops_bench
